// File: logic/rtc_weekly_scheduler.sv
// Purpose: Calendar clock with four weekly periods, offset window, four timers, relays and speed select.
// Assumes: APB slave, one clock, pins keypad_present and digital_input_line are asynchronous.
// Notes: Register index times four gives the byte address.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rtc_weekly_scheduler #(
  parameter int unsigned SECOND_CYCLES = rtc_sched_pkg::SECOND_CYCLES
) (
  // Clock, enable and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic keypad_present,
  input wire logic digital_input_line,
  // Schedule outputs
  output logic [3:0] timer_active_q,
  output logic [3:0] relay_q,
  output logic run_cmd_q,
  output logic reverse_q,
  output logic [1:0] speed_stage_q,
  output logic clock_display_q
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [1:0] keypad_sync_q;
  logic [1:0] di_sync_q;
  logic di_prev_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      keypad_sync_q <= 2'h0;
      di_sync_q <= 2'h0;
      di_prev_q <= 1'b0;
    end else if (ce) begin
      keypad_sync_q <= {keypad_sync_q[0], keypad_present};
      di_sync_q <= {di_sync_q[0], digital_input_line};
      di_prev_q <= di_sync_q[1];
    end
  end

  wire logic keypad_ok = keypad_sync_q[1];
  wire logic di_level = di_sync_q[1];
  wire logic di_rise = di_level & ~di_prev_q;

  // ----------------------------------------
  // Configuration store
  // ----------------------------------------
  logic [15:0] cfg_q [rtc_sched_pkg::CFG_COUNT];

  wire logic [1:0] func_sel = cfg_q[rtc_sched_pkg::IDX_FUNC][1:0];
  wire logic [1:0] off_sel = cfg_q[rtc_sched_pkg::IDX_OFF_SEL][1:0];
  wire logic [10:0] off_len = rtc_sched_pkg::minute_of_day(cfg_q[rtc_sched_pkg::IDX_OFF_DUR]);
  wire logic [2:0] speed_sel = cfg_q[rtc_sched_pkg::IDX_SPEED][2:0];
  wire logic [3:0] dir_bits = cfg_q[rtc_sched_pkg::IDX_DIR][3:0];
  wire logic [7:0] relay_sel = cfg_q[rtc_sched_pkg::IDX_RELAY][7:0];

  // ----------------------------------------
  // Calendar
  // ----------------------------------------
  logic [31:0] presc_q;
  logic [5:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [4:0] date_q;
  logic [3:0] month_q;
  logic [6:0] year_q;
  logic [2:0] wday_q;

  wire logic sec_tick = (presc_q == SECOND_CYCLES - 1);
  wire logic min_tick = sec_tick && (sec_q == rtc_sched_pkg::SECOND_MAX);
  wire logic hour_tick = min_tick && (min_q == rtc_sched_pkg::MINUTE_MAX);
  wire logic day_tick = hour_tick && (hour_q == rtc_sched_pkg::HOUR_MAX);
  wire logic month_tick = day_tick && (date_q == rtc_sched_pkg::days_in_month(year_q, month_q));
  wire logic year_tick = month_tick && (month_q == rtc_sched_pkg::MONTH_MAX);
  wire logic [10:0] now_minute = rtc_sched_pkg::minute_of_day({hour_q, min_q});

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  wire logic [4:0] idx = paddr[6:2];
  wire logic addr_ok = (paddr[1:0] == 2'h0) && !paddr[7];
  wire logic is_mon = (idx >= rtc_sched_pkg::IDX_DATE_MON);
  wire logic setup = psel && !penable;
  wire logic commit = psel && penable && pready_q && !pslverr_q;
  wire logic do_write = commit && pwrite;
  wire logic cfg_write = do_write && (idx < rtc_sched_pkg::IDX_DATE_SET);
  wire logic date_load = do_write && (idx == rtc_sched_pkg::IDX_DATE_SET);
  wire logic time_load = do_write && (idx == rtc_sched_pkg::IDX_TIME_SET);

  // Checks a written value against the documented range of its setting.
  function automatic logic time_ok(input logic [31:0] d);
    return (d[31:16] == 16'h0000) && (d[15:8] <= rtc_sched_pkg::HOUR_MAX) && (d[7:0] <= rtc_sched_pkg::MINUTE_MAX);
  endfunction : time_ok

  function automatic logic value_ok(input logic [4:0] i, input logic [31:0] d);
    logic [6:0] y;
    logic [3:0] m;
    logic [4:0] dd;
    logic [2:0] w;
    y = d[15:9];
    m = d[8:5];
    dd = d[4:0];
    w = d[18:16];
    if (i == rtc_sched_pkg::IDX_FUNC || i == rtc_sched_pkg::IDX_OFF_SEL) begin
      value_ok = (d <= 32'(rtc_sched_pkg::SEL_DI));
    end else if (i >= rtc_sched_pkg::IDX_TIME_BASE && i < rtc_sched_pkg::IDX_DAY_BASE) begin
      value_ok = time_ok(d);
    end else if (i >= rtc_sched_pkg::IDX_DAY_BASE && i < rtc_sched_pkg::IDX_OFF_SEL) begin
      value_ok = (d >= 32'(rtc_sched_pkg::WDAY_MIN)) && (d <= 32'(rtc_sched_pkg::WDAY_MAX));
    end else if (i == rtc_sched_pkg::IDX_OFF_DUR || i == rtc_sched_pkg::IDX_TIME_SET) begin
      value_ok = time_ok(d);
    end else if (i >= rtc_sched_pkg::IDX_MASK_BASE && i < rtc_sched_pkg::IDX_SPEED) begin
      value_ok = (d <= 32'(rtc_sched_pkg::MASK_MAX));
    end else if (i == rtc_sched_pkg::IDX_SPEED) begin
      value_ok = (d <= 32'(rtc_sched_pkg::SPEED_COMBINED));
    end else if (i == rtc_sched_pkg::IDX_DIR) begin
      value_ok = (d <= 32'h0000000F);
    end else if (i == rtc_sched_pkg::IDX_DISPLAY) begin
      value_ok = (d <= 32'h00000001);
    end else if (i == rtc_sched_pkg::IDX_RELAY) begin
      value_ok = (d <= 32'h000000FF);
    end else if (i == rtc_sched_pkg::IDX_DATE_SET) begin
      value_ok = (d[31:19] == 13'h0000) && (y >= rtc_sched_pkg::YEAR_MIN) && (y <= rtc_sched_pkg::YEAR_MAX)
                 && (m != 4'h0) && (m <= rtc_sched_pkg::MONTH_MAX) && (dd != 5'h00)
                 && (dd <= rtc_sched_pkg::days_in_month(y, m))
                 && (w >= rtc_sched_pkg::WDAY_MIN);
    end else begin
      value_ok = 1'b0;
    end
  endfunction : value_ok

  wire logic req_ok = addr_ok && (pwrite ? value_ok(idx, pwdata) : 1'b1);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < rtc_sched_pkg::CFG_COUNT; i++) begin
        cfg_q[i] <= (i >= int'(rtc_sched_pkg::IDX_DAY_BASE) && i < int'(rtc_sched_pkg::IDX_OFF_SEL))
                    ? rtc_sched_pkg::RST_DAY_CFG : rtc_sched_pkg::RST_CFG;
      end
    end else if (ce && cfg_write) begin
      cfg_q[idx] <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Calendar counter
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      presc_q <= 32'h00000000;
      sec_q <= 6'h00;
      min_q <= 8'h00;
      hour_q <= 8'h00;
    end else if (ce) begin
      if (time_load) begin
        presc_q <= 32'h00000000;
        sec_q <= 6'h00;
        min_q <= pwdata[7:0];
        hour_q <= pwdata[15:8];
      end else begin
        // Counting runs regardless of the display setting.
        presc_q <= sec_tick ? 32'h00000000 : presc_q + 32'h00000001;
        if (sec_tick) begin
          sec_q <= min_tick ? 6'h00 : sec_q + 6'h01;
        end
        if (min_tick) begin
          min_q <= hour_tick ? 8'h00 : min_q + 8'h01;
        end
        if (hour_tick) begin
          hour_q <= day_tick ? 8'h00 : hour_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      date_q <= rtc_sched_pkg::RST_DATE;
      month_q <= rtc_sched_pkg::RST_MONTH;
      year_q <= rtc_sched_pkg::RST_YEAR;
      wday_q <= rtc_sched_pkg::RST_WDAY;
    end else if (ce) begin
      if (date_load) begin
        date_q <= pwdata[4:0];
        month_q <= pwdata[8:5];
        year_q <= pwdata[15:9];
        wday_q <= pwdata[18:16];
      end else if (day_tick) begin
        wday_q <= (wday_q == rtc_sched_pkg::WDAY_MAX) ? rtc_sched_pkg::WDAY_MIN : wday_q + 3'h1;
        date_q <= month_tick ? 5'h01 : date_q + 5'h01;
        if (month_tick) begin
          month_q <= year_tick ? 4'h1 : month_q + 4'h1;
        end
        if (year_tick) begin
          year_q <= (year_q == rtc_sched_pkg::YEAR_MAX) ? rtc_sched_pkg::YEAR_MIN : year_q + 7'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Periods
  // ----------------------------------------
  logic [3:0] period_active;

  for (genvar p = 0; p < 4; p++) begin : g_period
    period_match u_period (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .start_time(cfg_q[32'(rtc_sched_pkg::IDX_TIME_BASE) + 2 * p]),
      .stop_time(cfg_q[32'(rtc_sched_pkg::IDX_TIME_BASE) + 2 * p + 1]),
      .start_day(cfg_q[32'(rtc_sched_pkg::IDX_DAY_BASE) + 2 * p][2:0]),
      .stop_day(cfg_q[32'(rtc_sched_pkg::IDX_DAY_BASE) + 2 * p + 1][2:0]),
      .now_minute(now_minute),
      .now_day(wday_q),
      .active_q(period_active[p])
    );
  end

  // ----------------------------------------
  // Schedule gate and offset window
  // ----------------------------------------
  logic off_on_q;
  logic [10:0] off_left_q;

  wire logic gate_sel = (func_sel == rtc_sched_pkg::SEL_ON) || (func_sel == rtc_sched_pkg::SEL_DI && di_level);
  wire logic sched_en = keypad_ok && gate_sel;
  wire logic off_enabled = (off_sel == rtc_sched_pkg::SEL_ON);
  wire logic off_start = (off_enabled && !off_on_q) || (off_sel == rtc_sched_pkg::SEL_DI && di_rise);
  wire logic off_active = (off_left_q != 11'h000);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      off_on_q <= 1'b0;
      off_left_q <= 11'h000;
    end else if (ce) begin
      off_on_q <= off_enabled;
      if (!sched_en || off_sel == rtc_sched_pkg::SEL_OFF) begin
        off_left_q <= 11'h000;
      end else if (off_start) begin
        off_left_q <= off_len;
      end else if (min_tick && off_active) begin
        off_left_q <= off_left_q - 11'h001;
      end
    end
  end

  // ----------------------------------------
  // Timers, relays and speed
  // ----------------------------------------
  wire logic [4:0] sources = {off_active, period_active};
  logic [3:0] timer_d;

  always_comb begin
    for (int t = 0; t < 4; t++) begin
      // Masks are independent, so periods may be shared freely between timers.
      timer_d[t] = sched_en && ((cfg_q[32'(rtc_sched_pkg::IDX_MASK_BASE) + t][4:0] & sources) != 5'h00);
    end
  end

  logic [3:0] relay_d;

  always_comb begin
    for (int r = 0; r < 4; r++) begin
      relay_d[r] = timer_active_q[relay_sel[2 * r +: 2]];
    end
  end

  wire logic combined = (speed_sel == rtc_sched_pkg::SPEED_COMBINED);
  wire logic [1:0] single_slot = 2'(speed_sel - 3'h1);
  wire logic [1:0] combo_stage = {timer_active_q[1], timer_active_q[0]};
  wire logic run_d = sched_en && (combined || (speed_sel != rtc_sched_pkg::SPEED_OFF
                                               && timer_active_q[single_slot]));
  wire logic [1:0] stage_d = combined ? combo_stage : 2'h0;
  wire logic reverse_d = combined ? dir_bits[combo_stage] : dir_bits[single_slot];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timer_active_q <= 4'h0;
      relay_q <= 4'h0;
      run_cmd_q <= 1'b0;
      reverse_q <= 1'b0;
      speed_stage_q <= 2'h0;
      clock_display_q <= 1'b0;
    end else if (ce) begin
      timer_active_q <= timer_d;
      relay_q <= relay_d;
      run_cmd_q <= run_d;
      reverse_q <= run_d && reverse_d;
      speed_stage_q <= run_d ? stage_d : 2'h0;
      clock_display_q <= cfg_q[rtc_sched_pkg::IDX_DISPLAY][0];
    end
  end

  // ----------------------------------------
  // Read mux and APB answer
  // ----------------------------------------
  wire logic [31:0] date_mon = {13'h0000, wday_q, year_q, month_q, date_q};
  wire logic [31:0] time_mon = {8'h00, hour_q, min_q, 2'h0, sec_q};
  wire logic [31:0] status = {20'h00000, keypad_ok, di_level, sched_en, off_active, period_active, timer_active_q};
  wire logic [31:0] read_d = (idx == rtc_sched_pkg::IDX_DATE_MON) ? date_mon
                           : (idx == rtc_sched_pkg::IDX_TIME_MON) ? time_mon
                           : (idx == rtc_sched_pkg::IDX_STATUS) ? status
                           : (idx < rtc_sched_pkg::IDX_DATE_SET) ? {16'h0000, cfg_q[idx]}
                           : 32'h00000000;
  wire logic err_d = !req_ok || (pwrite && is_mon);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup && err_d;
      prdata_q <= (setup && !pwrite && !err_d) ? read_d : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : rtc_weekly_scheduler

// File: logic/rtc_sched_pkg.sv
// Purpose: Shared constants and helpers for the weekly schedule clock.
// Assumes: 10 MHz system clock, APB register access with 32-bit data.
// Notes: Register byte address is four times the index below.
package rtc_sched_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [4:0] IDX_FUNC = 5'h00;
  localparam logic [4:0] IDX_TIME_BASE = 5'h01;
  localparam logic [4:0] IDX_DAY_BASE = 5'h09;
  localparam logic [4:0] IDX_OFF_SEL = 5'h11;
  localparam logic [4:0] IDX_OFF_DUR = 5'h12;
  localparam logic [4:0] IDX_MASK_BASE = 5'h13;
  localparam logic [4:0] IDX_SPEED = 5'h17;
  localparam logic [4:0] IDX_DIR = 5'h18;
  localparam logic [4:0] IDX_DISPLAY = 5'h19;
  localparam logic [4:0] IDX_RELAY = 5'h1A;
  localparam logic [4:0] IDX_DATE_SET = 5'h1B;
  localparam logic [4:0] IDX_TIME_SET = 5'h1C;
  localparam logic [4:0] IDX_DATE_MON = 5'h1D;
  localparam logic [4:0] IDX_TIME_MON = 5'h1E;
  localparam logic [4:0] IDX_STATUS = 5'h1F;
  localparam int unsigned CFG_COUNT = 27;

  // ----------------------------------------
  // Setting encodings
  // ----------------------------------------
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ON = 2'h1;
  localparam logic [1:0] SEL_DI = 2'h2;
  localparam logic [2:0] SPEED_OFF = 3'h0;
  localparam logic [2:0] SPEED_COMBINED = 3'h5;
  localparam logic [4:0] MASK_MAX = 5'h1F;

  // ----------------------------------------
  // Field limits and reset values
  // ----------------------------------------
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] MINUTE_MAX = 8'h3B;
  localparam logic [5:0] SECOND_MAX = 6'h3B;
  localparam logic [2:0] WDAY_MIN = 3'h1;
  localparam logic [2:0] WDAY_MAX = 3'h7;
  localparam logic [6:0] YEAR_MIN = 7'h0C;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [15:0] RST_DAY_CFG = 16'h0001;
  localparam logic [6:0] RST_YEAR = 7'h0C;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [4:0] RST_DATE = 5'h01;
  localparam logic [2:0] RST_WDAY = 3'h7;

  // Converts an hour:minute setting into minutes since midnight.
  function automatic logic [10:0] minute_of_day(input logic [15:0] t);
    return 11'(t[15:8]) * 11'h03C + 11'(t[7:0]);
  endfunction : minute_of_day

  // Number of days in a month; every year of the range divisible by four is a leap year.
  function automatic logic [4:0] days_in_month(input logic [6:0] year, input logic [3:0] month);
    case (month)
      4'h2: days_in_month = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'h1E;
      default: days_in_month = 5'h1F;
    endcase
  endfunction : days_in_month

endpackage : rtc_sched_pkg

// File: logic/period_match.sv
// Purpose: Decides whether one weekly time period is active.
// Assumes: Settings are already range-checked by the register file.
// Notes: Ranges that run past Sunday or past midnight wrap around.
`timescale 1ns/1ps
module period_match (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Period settings
  input wire logic [15:0] start_time,
  input wire logic [15:0] stop_time,
  input wire logic [2:0] start_day,
  input wire logic [2:0] stop_day,
  // Current calendar
  input wire logic [10:0] now_minute,
  input wire logic [2:0] now_day,
  // Result
  output logic active_q
);

  wire logic [10:0] t_start = rtc_sched_pkg::minute_of_day(start_time);
  wire logic [10:0] t_stop = rtc_sched_pkg::minute_of_day(stop_time);
  wire logic switched_off = (start_time == stop_time);
  wire logic day_in = (start_day <= stop_day) ? (now_day >= start_day && now_day <= stop_day)
                                              : (now_day >= start_day || now_day <= stop_day);
  // The stop minute itself still counts as active.
  wire logic time_in = (t_start <= t_stop) ? (now_minute >= t_start && now_minute <= t_stop)
                                           : (now_minute >= t_start || now_minute <= t_stop);
  wire logic active_d = ~switched_off & day_in & time_in;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b0;
    end else if (ce) begin
      active_q <= active_d;
    end
  end

endmodule : period_match

// File: tb/rtc_sched_chk.sv
// Purpose: Port-level checks of the weekly schedule clock.
// Assumes: Bound to the top module, one clock domain.
// Notes: None.
`timescale 1ns/1ps
module rtc_sched_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Schedule
  input wire logic keypad_present,
  input wire logic [3:0] timer_active_q,
  input wire logic [3:0] relay_q,
  input wire logic run_cmd_q,
  input wire logic reverse_q,
  input wire logic [1:0] speed_stage_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> s_access) else $error("pready late");
  chk_ready_one_cycle: assert property (pready && ce |=> !pready) else $error("pready held");
  chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  chk_misalign_refused: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  chk_stage_idle: assert property (!run_cmd_q |-> speed_stage_q == 2'h0 && !reverse_q)
    else $error("stage or direction while stopped");
  chk_keypad_gate: assert property (!keypad_present [*8] |-> timer_active_q == 4'h0 && !run_cmd_q)
    else $error("schedule active without keypad");
  chk_relay_follow: assert property ($past(timer_active_q) == 4'h0 |-> relay_q == 4'h0)
    else $error("relay without timer");
endmodule : rtc_sched_chk
bind rtc_weekly_scheduler rtc_sched_chk rtc_sched_chk_i (.clk_sys, .nrst, .ce, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .keypad_present, .timer_active_q, .relay_q, .run_cmd_q, .reverse_q, .speed_stage_q);

// File: tb/rtc_weekly_scheduler_tb.sv
// Purpose: Self-checking bench for the weekly schedule clock.
// Assumes: One second lasts ten clock cycles here.
// Notes: Registers are reached through APB tasks.
`timescale 1ns/1ps
module rtc_weekly_scheduler_tb;
  logic clk_sys, nrst, ce, psel, penable, pwrite, keypad_present, digital_input_line;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, run_cmd_q, reverse_q, clock_display_q;
  logic [3:0] timer_active_q, relay_q;
  logic [1:0] speed_stage_q;
  int fails, checks;
  rtc_weekly_scheduler #(.SECOND_CYCLES(10)) rtc_weekly_scheduler_i (.clk_sys, .nrst, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keypad_present, .digital_input_line,
    .timer_active_q, .relay_q, .run_cmd_q, .reverse_q, .speed_stage_q, .clock_display_q);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [4:0] idx, input logic [31:0] v);
    apb(1'b1, {1'b0, idx, 2'h0}, v);
    check("write status", {31'h0, err}, 32'h0);
  endtask : wr
  task automatic rdc(input string what, input logic [4:0] idx, input logic [31:0] exp);
    apb(1'b0, {1'b0, idx, 2'h0}, 32'h0);
    check(what, rd, exp);
  endtask : rdc
  task automatic outs(input logic [3:0] tmr, input logic run, input logic [1:0] stg, input logic rev);
    check("timers", {28'h0, timer_active_q}, {28'h0, tmr});
    check("run", {31'h0, run_cmd_q}, {31'h0, run});
    check("stage", {30'h0, speed_stage_q}, {30'h0, stg});
    check("reverse", {31'h0, reverse_q}, {31'h0, rev});
  endtask : outs
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [5:0] s;
    rdc("func reset", rtc_sched_pkg::IDX_FUNC, 32'h0);
    rdc("day reset", rtc_sched_pkg::IDX_DAY_BASE, 32'h1);
    rdc("date reset", rtc_sched_pkg::IDX_DATE_MON, 32'h0007_1821);
    apb(1'b1, 8'h80, 32'h1);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, {1'b0, rtc_sched_pkg::IDX_TIME_MON, 2'h0}, 32'h0);
    check("monitor write err", {31'h0, err}, 32'h1);
    apb(1'b1, 8'h02, 32'h0);
    check("misaligned err", {31'h0, err}, 32'h1);
    apb(1'b0, {1'b0, rtc_sched_pkg::IDX_TIME_MON, 2'h0}, 32'h0);
    s = rd[5:0];
    repeat (97) @(posedge clk_sys);
    apb(1'b0, {1'b0, rtc_sched_pkg::IDX_TIME_MON, 2'h0}, 32'h0);
    check("clock runs hidden", {26'h0, 6'(rd[5:0] - s)}, 32'hA);
    wr(rtc_sched_pkg::IDX_DISPLAY, 32'h1);
    repeat (2) @(posedge clk_sys);
    check("display bit", {31'h0, clock_display_q}, 32'h1);
    wr(rtc_sched_pkg::IDX_MASK_BASE, 32'h1F);
    rdc("mask readback", rtc_sched_pkg::IDX_MASK_BASE, 32'h1F);
    $display("Register test done.");
  endtask : t_regs
  task automatic t_periods;
    logic [4:0] ia [16] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h09, 5'h0A, 5'h0B, 5'h0C,
      5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h00, 5'h1C};
    logic [15:0] va [16] = '{16'h0B3B, 16'h0C00, 16'h0C00, 16'h0C00, 16'h0007, 16'h0007, 16'h0007, 16'h0007,
      16'h0001, 16'h0002, 16'h0003, 16'h0010, 16'h0001, 16'h0000, 16'h0001, 16'h0C00};
    foreach (ia[i]) begin
      wr(ia[i], {16'h0, va[i]});
    end
    wr(rtc_sched_pkg::IDX_RELAY, 32'h1B);
    repeat (10) @(posedge clk_sys);
    outs(4'h5, 1'b1, 2'h0, 1'b0);
    check("relays", {28'h0, relay_q}, 32'hA);
    apb(1'b0, {1'b0, rtc_sched_pkg::IDX_TIME_MON, 2'h0}, 32'h0);
    check("time monitor", {16'h0, rd[23:8]}, 32'h0C00);
    repeat (560) @(posedge clk_sys);
    check("stop minute", {28'h0, timer_active_q}, 32'h5);
    repeat (80) @(posedge clk_sys);
    check("after stop", {28'h0, timer_active_q}, 32'h0);
    $display("Period test done.");
  endtask : t_periods
  task automatic t_combined;
    wr(rtc_sched_pkg::IDX_SPEED, 32'h5);
    wr(rtc_sched_pkg::IDX_DIR, 32'h2);
    wr(rtc_sched_pkg::IDX_TIME_SET, 32'h0C00);
    repeat (10) @(posedge clk_sys);
    outs(4'h5, 1'b1, 2'h1, 1'b1);
    repeat (640) @(posedge clk_sys);
    outs(4'h0, 1'b1, 2'h0, 1'b0);
    keypad_present <= 1'b0;
    repeat (10) @(posedge clk_sys);
    outs(4'h0, 1'b0, 2'h0, 1'b0);
    keypad_present <= 1'b1;
    wr(rtc_sched_pkg::IDX_FUNC, 32'h0);
    wr(rtc_sched_pkg::IDX_TIME_SET, 32'h0C00);
    repeat (10) @(posedge clk_sys);
    check("gate off", {28'h0, timer_active_q}, 32'h0);
    $display("Combined test done.");
  endtask : t_combined
  task automatic t_offset;
    wr(rtc_sched_pkg::IDX_FUNC, 32'h2);
    wr(rtc_sched_pkg::IDX_OFF_SEL, 32'h2);
    wr(rtc_sched_pkg::IDX_OFF_DUR, 32'h0001);
    wr(rtc_sched_pkg::IDX_TIME_SET, 32'h0C00);
    repeat (10) @(posedge clk_sys);
    check("gate input low", {28'h0, timer_active_q}, 32'h0);
    digital_input_line <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check("offset start", {28'h0, timer_active_q}, 32'hD);
    repeat (600) @(posedge clk_sys);
    check("offset end", {28'h0, timer_active_q}, 32'h0);
    $display("Offset test done.");
  endtask : t_offset
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, digital_input_line} = '0;
    ce = 1'b1;
    keypad_present = 1'b1;
    fails = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_periods();
    t_combined();
    t_offset();
    print_verdict();
  end
endmodule : rtc_weekly_scheduler_tb
